// file: async_tx_threshold_control_tb_top.sv
// Self-checking bench for the transmit start-threshold control.
// Assumes the checker is bound and the EEPROM model drives the load port.
`timescale 1ns/1ps
`default_nettype none
module async_tx_threshold_control_tb_top
	import tx_tuning_pkg::*;
	;
	logic ref_clk = 0, reset = 1, regWrite = 0, regRead = 0, loadReq = 0, eepromLoad;
	logic phyEnhanceGate = 1, retriesZero = 0, eopIn = 0, fifoEmpty = 0, retryReq = 0, txDone = 0;
	logic txGo, inOrderOnly, storeForward, irq;
	logic [7:0] regAddr = 8'h0;
	logic [31:0] regWdata = 32'h0, regRdata, eepromData, image = 32'h0000_1000;
	logic [LANE_W-1:0] fillBytes = 4'h0;
	logic [LANE_W-1:0] drainBytes = 4'h0;
	int n_mismatch = 0, checks_done = 0;
	// Clock and design
	always #10 ref_clk = ~ref_clk;
	tx_threshold_ctrl i_dut (.ref_clk, .reset, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
		.eepromLoad, .eepromData, .phyEnhanceGate, .retriesZero, .fillBytes, .drainBytes, .eopIn,
		.fifoEmpty, .retryReq, .txDone, .txGo, .inOrderOnly, .storeForward, .irq);
	eeprom_loader_model i_eep (.ref_clk, .loadReq, .image, .eepromLoad, .eepromData);
	// Shared helpers
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wt(int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk);
		regWrite <= 1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e);
		@(posedge ref_clk);
		regRead <= 1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 0;
		#1;
		chk("regRdata", regRdata, e);
	endtask
	task automatic feed(int n);
		@(posedge ref_clk);
		while (n > 0) begin
			fillBytes <= (n > 15) ? 4'hF : 4'(n);
			n -= 15;
			@(posedge ref_clk);
		end
		fillBytes <= 4'h0;
	endtask
	task automatic rst();
		@(posedge ref_clk);
		reset <= 1;
		phyEnhanceGate <= 1;
		retriesZero <= 0;
		@(posedge ref_clk);
		reset <= 0;
	endtask
	// Reset value, masking of fixed bits, EEPROM load, unmapped read
	task automatic t_regs();
		rd(TUNING_ADDR, TUNING_RESET);
		wr(TUNING_ADDR, 32'hFFFF_FFFF);
		rd(TUNING_ADDR, 32'h0000_B000);
		rd(8'h10, 32'h0);
		@(posedge ref_clk);
		loadReq <= 1;
		@(posedge ref_clk);
		loadReq <= 0;
		rd(TUNING_ADDR, 32'h0000_1000);
	endtask
	// Every level code: start exactly at its threshold, 2K waits for end of packet
	task automatic t_levels();
		int thr[4] = '{2048, 1740, 1024, 512};
		for (int c = 0; c < 4; c++) begin
			rst();
			wr(TUNING_ADDR, 32'(c << 12));
			feed(thr[c] - 1);
			wt(3);
			chk("txGo below", txGo, 0);
			feed(1);
			wt(3);
			chk("txGo at level", txGo, c != 0);
			chk("storeForward level", storeForward, c == 0);
			@(posedge ref_clk);
			eopIn <= 1;
			@(posedge ref_clk);
			eopIn <= 0;
			wt(3);
			chk("txGo packet in", txGo, 1);
			@(posedge ref_clk);
			txDone <= 1;
			@(posedge ref_clk);
			txDone <= 0;
			wt(2);
			chk("txGo done", txGo, 0);
		end
	endtask
	// Gate low, zero retries, retry: none starts at the 512 level
	task automatic t_block();
		for (int m = 0; m < 3; m++) begin
			rst();
			phyEnhanceGate <= (m != 0);
			retriesZero <= (m == 1);
			wr(TUNING_ADDR, 32'h0000_B000);
			retryReq <= (m == 2);
			feed(600);
			retryReq <= 0;
			wt(3);
			chk("txGo held", txGo, 0);
			chk("inOrderOnly", inOrderOnly, m != 0);
		end
	endtask
	// Underrun, fallback, resend of the whole packet, interrupt
	task automatic t_underrun();
		rst();
		wr(IRQ_MASK_ADDR, 32'h1);
		wr(TUNING_ADDR, 32'h0000_3000);
		feed(512);
		wt(3);
		chk("txGo early", txGo, 1);
		@(posedge ref_clk);
		fifoEmpty <= 1;
		@(posedge ref_clk);
		fifoEmpty <= 0;
		wt(2);
		chk("txGo underrun", txGo, 0);
		chk("storeForward", storeForward, 1);
		chk("irq", irq, 1);
		feed(600);
		wt(3);
		chk("txGo fallback", txGo, 0);
		@(posedge ref_clk);
		eopIn <= 1;
		@(posedge ref_clk);
		eopIn <= 0;
		wt(3);
		chk("txGo resend", txGo, 1);
		@(posedge ref_clk);
		txDone <= 1;
		@(posedge ref_clk);
		txDone <= 0;
		rd(IRQ_STATUS_ADDR, 32'h7);
		rd(IRQ_STATUS_ADDR, 32'h7);
		wr(IRQ_MASK_ADDR, 32'h0);
		wt(2);
		chk("irq masked", irq, 0);
		wr(IRQ_STATUS_ADDR, 32'h7);
		rd(IRQ_STATUS_ADDR, 32'h0);
		rd(STATE_ADDR, 32'h0004_5821);
		@(posedge ref_clk);
		drainBytes <= 4'h8;
		@(posedge ref_clk);
		drainBytes <= 4'h0;
		rd(STATE_ADDR, 32'h0004_5021);
	endtask
	// Verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		reset <= 0;
		t_regs();
		t_levels();
		t_block();
		t_underrun();
		test_done();
	end
	// Watchdog well past the expected run
	initial begin
		#200000;
		n_mismatch++;
		test_done();
	end
endmodule
`default_nettype wire

// file: eeprom_loader_model.sv
// Serial EEPROM loader model: one control image per request.
// Assumes the bench raises loadReq for one cycle on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module eeprom_loader_model (
	input wire logic ref_clk,
	input wire logic loadReq,
	input wire logic [31:0] image,
	output logic eepromLoad,
	output logic [31:0] eepromData
);
	logic load_r = 1'b0;
	logic [31:0] data_r = 32'h0;
	// One-cycle load strobe, data inverted outside it
	always @(posedge ref_clk) begin
		load_r <= loadReq;
		data_r <= loadReq ? image : ~image;
	end
	assign eepromLoad = load_r;
	assign eepromData = data_r;
endmodule
`default_nettype wire

// file: tx_fill_tracker.sv
// FIFO occupancy tracker for the asynchronous transmit path.
// Assumes byte counts arrive synchronous to ref_clk and never overflow the FIFO.
`timescale 1ns/1ps
`default_nettype none
module tx_fill_tracker
	import tx_tuning_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [LANE_W-1:0] addBytes,
	input wire logic [LANE_W-1:0] takeBytes,
	output logic [OCC_W-1:0] occupancy_r
);
	logic [OCC_W-1:0] occupancy_nxt;
	logic [OCC_W-1:0] addWide;
	logic [OCC_W-1:0] takeWide;

	// Widen lane counts and form the next fill level
	assign addWide = {{(OCC_W-LANE_W){1'b0}}, addBytes};
	assign takeWide = {{(OCC_W-LANE_W){1'b0}}, takeBytes};
	assign occupancy_nxt = (occupancy_r + addWide < takeWide) ? '0 : occupancy_r + addWide - takeWide;

	// Fill level register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			occupancy_r <= '0;
		end else begin
			occupancy_r <= occupancy_nxt;
		end
	end
endmodule
`default_nettype wire

// file: tx_threshold_assertions.sv
// Port-level checker for the transmit start-threshold control.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tx_threshold_assertions
	import tx_tuning_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic regRead,
	input wire logic [31:0] regRdata,
	input wire logic phyEnhanceGate,
	input wire logic retriesZero,
	input wire logic retryReq,
	input wire logic txDone,
	input wire logic txGo,
	input wire logic inOrderOnly,
	input wire logic storeForward
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// Gate low for two edges, retries zero for two edges
	sequence gateOff2;
		!phyEnhanceGate [*2];
	endsequence
	sequence noRetries2;
		retriesZero [*2];
	endsequence
	// Read data of a control register read
	sequence tuningRead;
		$past(regRead) && $past(regAddr) == TUNING_ADDR;
	endsequence
	// Register port read data
	rd_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0) else $error("read data not idle");
	rsvd_high_a: assert property (tuningRead |-> regRdata[31:16] == 16'h0) else $error("upper bits set");
	bit11_zero_a: assert property (tuningRead |-> !regRdata[11]) else $error("bit 11 set");
	bit14_zero_a: assert property (tuningRead |-> !regRdata[14]) else $error("bit 14 set");
	unmapped_zero_a: assert property ($past(regRead) && $past(regAddr) == 8'h10 |-> regRdata == 32'h0)
		else $error("unmapped read not zero");
	// Transmit controls
	gate_order_a: assert property (gateOff2 |-> !inOrderOnly) else $error("reorder off without gate");
	retries_sf_a: assert property (noRetries2 |-> storeForward) else $error("no store and forward");
	retry_sf_a: assert property (retryReq |-> ##2 storeForward) else $error("retry not buffered");
	done_drop_a: assert property (txGo && txDone |=> !txGo) else $error("send stays after done");
endmodule
bind tx_threshold_ctrl tx_threshold_assertions i_chk (.ref_clk, .reset, .regAddr, .regRead, .regRdata,
	.phyEnhanceGate, .retriesZero, .retryReq, .txDone, .txGo, .inOrderOnly, .storeForward);
`default_nettype wire

// file: tx_threshold_ctrl.sv
// Start-threshold control for the asynchronous transmit path with its register port.
// Assumes the FIFO, the link drain and the EEPROM loader sit outside, all on ref_clk.
// Every output is registered; read data stand only in the cycle after the read strobe.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tx_threshold_ctrl
	import tx_tuning_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic eepromLoad,
	input wire logic [31:0] eepromData,
	input wire logic phyEnhanceGate,
	input wire logic retriesZero,
	input wire logic [LANE_W-1:0] fillBytes,
	input wire logic [LANE_W-1:0] drainBytes,
	input wire logic eopIn,
	input wire logic fifoEmpty,
	input wire logic retryReq,
	input wire logic txDone,
	output logic txGo,
	output logic inOrderOnly,
	output logic storeForward,
	output logic irq
);
	logic [31:0] tuning_r;
	logic [31:0] tuning_nxt;
	logic [IRQ_W-1:0] irqStatus_r;
	logic [IRQ_W-1:0] irqStatus_nxt;
	logic [IRQ_W-1:0] irqMask_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic txGo_r;
	logic inOrder_r;
	logic storeFwd_r;
	logic irq_r;
	logic fallback_r;
	logic retrying_r;
	logic eopResident_r;
	tx_state_t state_r;
	tx_state_t state_nxt;
	logic [OCC_W-1:0] occupancy;
	logic [IRQ_W-1:0] irqMask_nxt;
	logic eopResident_nxt;
	logic retrying_nxt;
	logic fallback_nxt;
	logic txGo_nxt;
	logic inOrder_nxt;
	logic storeFwd_nxt;
	logic irq_nxt;
	logic [31:0] statusWord;
	logic [31:0] maskWord;

	// Address decode
	wire hitTuning = regAddr == TUNING_ADDR;
	wire hitStatus = regAddr == IRQ_STATUS_ADDR;
	wire hitMask = regAddr == IRQ_MASK_ADDR;
	wire hitState = regAddr == STATE_ADDR;
	wire swTuningWrite = regWrite && hitTuning;
	wire swStatusWrite = regWrite && hitStatus;
	wire swMaskWrite = regWrite && hitMask;

	// Control register load, EEPROM image takes precedence
	wire loadTuning = eepromLoad || swTuningWrite; // RULE2
	wire [31:0] loadValue = eepromLoad ? eepromData : regWdata; // RULE2
	// Only bits 15, 13 and 12 hold state; 31-16, 14 and 11 stay zero
	assign tuning_nxt = loadTuning ? (loadValue & TUNING_WRITABLE) : tuning_r; // RULE3 RULE13 RULE15

	// Effective settings, enhancement bits gated by the external enable
	wire reorderOffBit = tuning_r[REORDER_OFF_BIT];
	wire [1:0] levelField = tuning_r[LEVEL_HI:LEVEL_LO];
	wire reorderOffEff = phyEnhanceGate && reorderOffBit; // RULE1 RULE4
	wire [1:0] levelEff = phyEnhanceGate ? levelField : LEVEL_1K7; // RULE1 RULE5

	// Store-and-forward sources
	wire sfByLevel = levelEff == LEVEL_2K; // RULE11
	wire sfMode = sfByLevel || retriesZero || fallback_r || retrying_r; // RULE6 RULE7 RULE12
	wire [OCC_W-1:0] threshold = levelBytes(levelEff); // RULE5
	wire levelReached = !sfMode && (occupancy >= threshold); // RULE8
	wire startOk = levelReached || eopResident_r; // RULE8 RULE10 RULE11
	wire underrun = (state_r == ST_SEND) && fifoEmpty && !eopResident_r && !txDone; // RULE9
	wire startEvent = (state_r != ST_SEND) && (state_nxt == ST_SEND);
	wire dataSeen = (fillBytes != '0) || eopIn;

	// Occupancy counter
	tx_fill_tracker fillTracker (
		.ref_clk(ref_clk),
		.reset(reset),
		.addBytes(fillBytes),
		.takeBytes(drainBytes),
		.occupancy_r(occupancy)
	);

	// Sequencing next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (dataSeen || eopResident_r) begin
					state_nxt = ST_FILL;
				end
			end
			ST_FILL: begin
				if (startOk) begin
					state_nxt = ST_SEND; // RULE8 RULE11
				end
			end
			ST_SEND: begin
				if (txDone) begin
					state_nxt = ST_IDLE;
				end else if (underrun) begin
					state_nxt = ST_HOLD; // RULE9
				end
			end
			ST_HOLD: begin
				if (eopResident_r) begin
					state_nxt = ST_SEND; // RULE10
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Interrupt events, one bit per status position
	wire [IRQ_W-1:0] irqEvents = {txDone && (state_r == ST_SEND), startEvent, underrun};
	// Write-one-to-clear pattern from a software status write
	wire [IRQ_W-1:0] irqClear = swStatusWrite ? regWdata[IRQ_W-1:0] : '0;
	// Sticky status, an event in the clearing cycle wins
	assign irqStatus_nxt = (irqStatus_r & ~irqClear) | irqEvents;
	// Mask follows software writes only
	assign irqMask_nxt = swMaskWrite ? regWdata[IRQ_W-1:0] : irqMask_r;
	// Level request from any enabled status bit
	wire irqAny = |(irqStatus_nxt & irqMask_r);
	assign irq_nxt = irqAny;

	// State snapshot for software
	wire [31:0] stateWord = {8'h00, 4'h0, occupancy, 1'b0, retrying_r, fallback_r, eopResident_r, state_r};
	// Status and mask widened to the port width
	assign statusWord = {{(32-IRQ_W){1'b0}}, irqStatus_r};
	assign maskWord = {{(32-IRQ_W){1'b0}}, irqMask_r};

	// Read data mux, unmapped reads return zero
	assign rdata_nxt = !regRead ? '0 :
		hitTuning ? tuning_r : // RULE3 RULE13 RULE15
		hitStatus ? statusWord :
		hitMask ? maskWord :
		hitState ? stateWord : '0;

	// Token arriving with completion is kept for the next packet
	assign eopResident_nxt = eopIn || (eopResident_r && !txDone);

	// Retry buffering lasts until the retried packet completes
	assign retrying_nxt = retryReq || (retrying_r && !txDone); // RULE7

	// Fallback set by an underrun, cleared by a reload; the set wins
	assign fallback_nxt = underrun || (fallback_r && !loadTuning); // RULE6 RULE9

	// Output next values
	assign txGo_nxt = state_nxt == ST_SEND;
	assign inOrder_nxt = reorderOffEff; // RULE4
	assign storeFwd_nxt = sfMode || underrun; // RULE12

	// Control register, reset to the 1.7K level
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tuning_r <= TUNING_RESET;
		end else begin
			tuning_r <= tuning_nxt;
		end
	end

	// Interrupt status register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irqStatus_r <= '0;
		end else begin
			irqStatus_r <= irqStatus_nxt;
		end
	end

	// Interrupt mask register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irqMask_r <= '0;
		end else begin
			irqMask_r <= irqMask_nxt;
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Sequencer state
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// End-of-packet token resident flag
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			eopResident_r <= 1'b0;
		end else begin
			eopResident_r <= eopResident_nxt;
		end
	end

	// Retry in progress flag
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			retrying_r <= 1'b0;
		end else begin
			retrying_r <= retrying_nxt;
		end
	end

	// Store-and-forward fallback after an underrun
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fallback_r <= 1'b0;
		end else begin
			fallback_r <= fallback_nxt;
		end
	end

	// Send output
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			txGo_r <= 1'b0;
		end else begin
			txGo_r <= txGo_nxt;
		end
	end

	// In-sequence output
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			inOrder_r <= 1'b0;
		end else begin
			inOrder_r <= inOrder_nxt;
		end
	end

	// Store-and-forward output, safe value in reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			storeFwd_r <= 1'b1;
		end else begin
			storeFwd_r <= storeFwd_nxt;
		end
	end

	// Interrupt output
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// Ports straight from their flip-flops
	assign regRdata = rdata_r;
	assign txGo = txGo_r;
	assign inOrderOnly = inOrder_r;
	assign storeForward = storeFwd_r;
	assign irq = irq_r;
endmodule
`default_nettype wire

// file: tx_tuning_pkg.sv
// Constants, register map and helpers for the transmit start-threshold control.
// Assumes a 32-bit register port with byte addresses and a single 50 MHz clock.
//
// How it works
// RULE1: Enhancement bits act only while the external enhancement gate input is high.
// RULE2: Control register loads from software writes or from the serial EEPROM loader.
// RULE3: Bits 31 to 16 of the control register always read as zero.
// RULE4: Reorder-off bit forces strictly in-sequence asynchronous transmit processing.
// RULE5: Level code 00=2K, 01=1.7K default, 10=1K, 11=512 bytes.
// RULE6: Programmed level applies only until the first FIFO underrun; the code applies it again after the next control register load.
// RULE7: A retried packet uses the 2K threshold, fully buffered first.
// RULE8: Below 2K, start at threshold or on whole packet checked in.
// RULE9: FIFO empty before packet end is an underrun, then store-and-forward.
// RULE10: After underrun, second attempt waits until whole packet is resident.
// RULE11: At 2K, transmit only after the end-of-packet token entered the FIFO.
// RULE12: Zero transmit retries count forces store-and-forward always.
// RULE13: Bit 11 is read-only and reads as zero.
// RULE14: Software normally keeps the 1.7K level, the usual best choice.
// RULE15: Bit 14 is read-only and reads as zero.
`default_nettype none
package tx_tuning_pkg;
	// Register byte addresses
	localparam logic [7:0] TUNING_ADDR = 8'hF4;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'hE0;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'hE4;
	localparam logic [7:0] STATE_ADDR = 8'hE8;
	// Control register fields
	localparam int REORDER_OFF_BIT = 15;
	localparam int LEVEL_HI = 13;
	localparam int LEVEL_LO = 12;
	localparam logic [31:0] TUNING_RESET = 32'h0000_1000;
	localparam logic [31:0] TUNING_WRITABLE = 32'h0000_B000;
	// Start-level codes
	localparam logic [1:0] LEVEL_2K = 2'h0;
	localparam logic [1:0] LEVEL_1K7 = 2'h1;
	localparam logic [1:0] LEVEL_1K = 2'h2;
	localparam logic [1:0] LEVEL_512 = 2'h3;
	// Thresholds in bytes
	localparam int OCC_W = 12;
	localparam logic [OCC_W-1:0] BYTES_2K = 12'h800;
	localparam logic [OCC_W-1:0] BYTES_1K7 = 12'h6CC;
	localparam logic [OCC_W-1:0] BYTES_1K = 12'h400;
	localparam logic [OCC_W-1:0] BYTES_512 = 12'h200;
	// Interrupt status bits
	localparam int IRQ_W = 3;
	localparam int IRQ_UNDERRUN = 0;
	localparam int IRQ_TX_START = 1;
	localparam int IRQ_TX_DONE = 2;
	// Lane width of per-cycle byte counts
	localparam int LANE_W = 4;

	// Transmit sequencing states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FILL = 4'h2,
		ST_SEND = 4'h4,
		ST_HOLD = 4'h8
	} tx_state_t;

	// Threshold in bytes for a level code
	function automatic logic [OCC_W-1:0] levelBytes(input logic [1:0] code);
		case (code)
			LEVEL_2K: levelBytes = BYTES_2K;
			LEVEL_1K7: levelBytes = BYTES_1K7;
			LEVEL_1K: levelBytes = BYTES_1K;
			default: levelBytes = BYTES_512;
		endcase
	endfunction
endpackage
`default_nettype wire
